// [bench/timer_interrupt_request_outputs_test.sv]
/*
  Self-checking bench for the timer interrupt request block.
  Assumes the strobe register port and one 10 MHz clock, clk_en driven here.
*/
`timescale 1ns/1ps
module timer_interrupt_request_outputs_test;
  logic ref_clk, rst, en, wr_stb, rd_stb, pin, cov;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] chan_event;
  logic [6:0] seen;
  logic irq;
  tir_pkg::tir_req_t req;
  int miscompares = 0;
  int samples_checked = 0;
  tir_top tir_top_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .chan_event(chan_event), .counter_overflow_evt(cov), .accum_input_pin(pin),
    .req(req), .irq(irq));
  tir_irq_ctrl_model tir_irq_ctrl_model_inst (.ref_clk(ref_clk), .rst(rst), .req(req),
    .irq(irq), .seen_ff(seen));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Extra cycle after a write: enables reach req in the same cycle as the register
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge ref_clk) wr_stb <= 1'b0;
    @(posedge ref_clk) #1;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge ref_clk) rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task evt(input logic [3:0] c, input logic o);
    @(posedge ref_clk) {chan_event, cov} <= {c, o};
    @(posedge ref_clk) {chan_event, cov} <= 5'h00;
    #1;
  endtask : evt
  // Pin passes a 2-FF synchroniser, so allow several cycles
  task pin_to(input logic l);
    @(posedge ref_clk) pin <= l;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : pin_to
  task end_sim;
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    {rst, en, wr_stb, rd_stb, pin, cov, addr, wdata, chan_event} = {2'b11, 48'h0};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wr(tir_pkg::OFF_CHAN_EN, 32'h5);
    evt(4'hf, 1'b0);
    chk({24'h0, req, irq}, 32'h51);
    rd(tir_pkg::OFF_CHAN_FLAG, v);
    chk(v, 32'hf);
    wr(tir_pkg::OFF_CHAN_FLAG, 32'h1);
    chk({25'h0, req}, 32'h20);
    wr(tir_pkg::OFF_CHAN_EN, 32'hf);
    chk({25'h0, req}, 32'h70);
    wr(tir_pkg::OFF_CHAN_FLAG, 32'he);
    chk({24'h0, req, irq}, 32'h0);
    $display("channel test done");
    wr(tir_pkg::OFF_ACC_CTL, 32'h4);
    evt(4'h0, 1'b1);
    chk({25'h0, req}, 32'h1);
    wr(tir_pkg::OFF_OVF_FLAG, 32'h0);
    rd(tir_pkg::OFF_OVF_FLAG, v);
    chk(v, 32'h4);
    wr(tir_pkg::OFF_OVF_FLAG, 32'h4);
    chk({25'h0, req}, 32'h0);
    $display("counter overflow test done");
    wr(tir_pkg::OFF_ACC_CTL, 32'h33);
    wr(tir_pkg::OFF_ACC_CNT, 32'hfffe);
    pin_to(1'b1);
    chk({25'h0, req}, 32'h4);
    rd(tir_pkg::OFF_ACC_CNT, v);
    chk(v, 32'hffff);
    pin_to(1'b0);
    rd(tir_pkg::OFF_ACC_CNT, v);
    chk(v, 32'hffff);
    pin_to(1'b1);
    chk({25'h0, req}, 32'h6);
    rd(tir_pkg::OFF_ACC_CNT, v);
    chk(v, 32'h0);
    $display("event mode test done");
    wr(tir_pkg::OFF_ACC_CTL, 32'h39);
    wr(tir_pkg::OFF_OVF_FLAG, 32'h7);
    chk({25'h0, req}, 32'h0);
    pin_to(1'b0);
    chk({25'h0, req}, 32'h4);
    wr(tir_pkg::OFF_ACC_CTL, 32'h38);
    chk({24'h0, req, irq}, 32'h0);
    rd(8'h40, v);
    chk(v, 32'h0);
    chk({25'h0, seen}, 32'h7f);
    $display("gated mode test done");
    wr(tir_pkg::OFF_ACC_CTL, 32'h21);
    wr(tir_pkg::OFF_OVF_FLAG, 32'h7);
    wr(tir_pkg::OFF_ACC_CNT, 32'h0);
    pin_to(1'b1);
    chk({25'h0, req}, 32'h0);
    pin_to(1'b0);
    chk({25'h0, req}, 32'h4);
    rd(tir_pkg::OFF_ACC_CNT, v);
    chk(v, 32'h1);
    $display("falling edge test done");
    @(posedge ref_clk) en <= 1'b0;
    wr(tir_pkg::OFF_OVF_FLAG, 32'h7);
    evt(4'hf, 1'b1);
    chk({24'h0, req, irq}, 32'h9);
    @(posedge ref_clk) en <= 1'b1;
    rd(tir_pkg::OFF_OVF_FLAG, v);
    chk(v, 32'h1);
    $display("clock enable test done");
    end_sim();
  end
endmodule : timer_interrupt_request_outputs_test

// [bench/tir_irq_ctrl_model.sv]
/*
  Behavioural stand-in for the system interrupt controller.
  Assumes level requests on ref_clk; it only records which lines were raised.
*/
`timescale 1ns/1ps
module tir_irq_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tir_pkg::tir_req_t req,
  input wire logic irq,
  output logic [6:0] seen_ff
);
  // Sticky record so every separate request line can be proven reachable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_ff <= 7'h00;
    end else if (irq) begin
      seen_ff <= seen_ff | req;
    end
  end
endmodule : tir_irq_ctrl_model

// [verilog/tir_pkg.sv]
/*
  Constants, register map and state layout of the timer interrupt request block.
  Assumes a plain strobe register port, one clock, and same-clock event pulses.
*/
package tir_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 4;
  localparam int ACC_W = 16;
  localparam int DIV_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CHAN_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CHAN_FLAG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACC_CTL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OVF_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ACC_CNT = 8'h10;
  localparam int CTL_W = 6;
  localparam int CTL_AI_IE = 0;
  localparam int CTL_AO_IE = 1;
  localparam int CTL_CO_IE = 2;
  localparam int CTL_GATED = 3;
  localparam int CTL_POL = 4;
  localparam int CTL_ACC_EN = 5;
  localparam int FLG_W = 3;
  localparam int FLG_AI = 0;
  localparam int FLG_AO = 1;
  localparam int FLG_CO = 2;
  localparam logic [ACC_W-1:0] ACC_MAX = 16'hffff;
  localparam logic [ACC_W-1:0] ACC_ZERO = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_LAST = 6'h3f;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  localparam logic [ACC_W-1:0] ACC_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [NCH-1:0] chan;
    logic acc_in;
    logic acc_ovf;
    logic cnt_ovf;
  } tir_req_t;

  typedef struct packed {
    logic [NCH-1:0] chan_en;
    logic [NCH-1:0] chan_flag;
    logic [CTL_W-1:0] ctl;
    logic [FLG_W-1:0] ovf_flag;
    logic [ACC_W-1:0] acc_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_prev;
    tir_req_t req;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } tir_state_t;

  localparam tir_state_t ST_RESET = '0;
endpackage : tir_pkg

// [verilog/tir_top.sv]
/*
  Interrupt request generation for four capture/compare channels, the pulse
  accumulator and the main counter overflow, with the accumulator itself.
  Assumes channel and counter overflow events are one-cycle pulses on ref_clk;
  the accumulator pin is asynchronous and is synchronised here.
*/
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module tir_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [tir_pkg::ADDR_W-1:0] addr,
  input wire logic [tir_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [tir_pkg::DATA_W-1:0] rdata,
  input wire logic [tir_pkg::NCH-1:0] chan_event,
  input wire logic counter_overflow_evt,
  input wire logic accum_input_pin,
  output tir_pkg::tir_req_t req,
  output logic irq
);
  tir_pkg::tir_state_t s_ff;
  tir_pkg::tir_state_t nxt_s;
  logic act;
  logic act_prev;
  logic sel_edge;
  logic trail_edge;
  logic div_tick;
  logic acc_inc;
  logic ai_evt;
  logic ao_evt;
  logic wr_chan_flag;
  logic wr_ovf_flag;
  logic wr_cnt;

  always_comb begin
    nxt_s = s_ff;
    // Second stage alone feeds the edge logic
    nxt_s.pin_sync1 = accum_input_pin;
    nxt_s.pin_sync2 = s_ff.pin_sync1;
    nxt_s.pin_prev = s_ff.pin_sync2;
    act = s_ff.ctl[tir_pkg::CTL_POL] ? s_ff.pin_sync2 : ~s_ff.pin_sync2;
    act_prev = s_ff.ctl[tir_pkg::CTL_POL] ? s_ff.pin_prev : ~s_ff.pin_prev;
    sel_edge = act & ~act_prev;
    trail_edge = ~act & act_prev;
    // Divide-by-64 runs free while enabled, so gate phase is not aligned
    div_tick = s_ff.div_cnt == tir_pkg::DIV_LAST;
    if (s_ff.ctl[tir_pkg::CTL_ACC_EN]) begin
      nxt_s.div_cnt = s_ff.div_cnt + tir_pkg::DIV_ONE;
    end
    acc_inc = s_ff.ctl[tir_pkg::CTL_ACC_EN] &
              (s_ff.ctl[tir_pkg::CTL_GATED] ? (div_tick & act) : sel_edge);
    ai_evt = s_ff.ctl[tir_pkg::CTL_ACC_EN] &
             (s_ff.ctl[tir_pkg::CTL_GATED] ? trail_edge : sel_edge);
    ao_evt = acc_inc & (s_ff.acc_cnt == tir_pkg::ACC_MAX);
    wr_chan_flag = wr_stb && (addr == tir_pkg::OFF_CHAN_FLAG);
    wr_ovf_flag = wr_stb && (addr == tir_pkg::OFF_OVF_FLAG);
    wr_cnt = wr_stb && (addr == tir_pkg::OFF_ACC_CNT);
    if (wr_stb && (addr == tir_pkg::OFF_CHAN_EN)) begin
      nxt_s.chan_en = wdata[tir_pkg::NCH-1:0];
    end else if (wr_stb && (addr == tir_pkg::OFF_ACC_CTL)) begin
      nxt_s.ctl = wdata[tir_pkg::CTL_W-1:0];
    end
    // Software write takes the counter over a same-cycle increment
    if (wr_cnt) begin
      nxt_s.acc_cnt = wdata[tir_pkg::ACC_W-1:0];
    end else if (acc_inc) begin
      nxt_s.acc_cnt = s_ff.acc_cnt + tir_pkg::ACC_ONE;
    end
    // Set wins over a same-cycle clear so no event is lost
    nxt_s.chan_flag = (s_ff.chan_flag &
                       ~(wr_chan_flag ? wdata[tir_pkg::NCH-1:0] : '0)) | chan_event;
    nxt_s.ovf_flag = (s_ff.ovf_flag &
                      ~(wr_ovf_flag ? wdata[tir_pkg::FLG_W-1:0] : '0)) |
                     {counter_overflow_evt, ao_evt, ai_evt};
    // Requests from next values so outputs match the registered flags
    nxt_s.req.chan = nxt_s.chan_flag & nxt_s.chan_en;
    nxt_s.req.acc_in = nxt_s.ovf_flag[tir_pkg::FLG_AI] &
                       nxt_s.ctl[tir_pkg::CTL_AI_IE];
    nxt_s.req.acc_ovf = nxt_s.ovf_flag[tir_pkg::FLG_AO] &
                        nxt_s.ctl[tir_pkg::CTL_AO_IE];
    nxt_s.req.cnt_ovf = nxt_s.ovf_flag[tir_pkg::FLG_CO] &
                        nxt_s.ctl[tir_pkg::CTL_CO_IE];
    nxt_s.irq = |nxt_s.req;
    nxt_s.rdata = tir_pkg::RD_ZERO;
    if (rd_stb) begin
      if (addr == tir_pkg::OFF_CHAN_EN) begin
        nxt_s.rdata[tir_pkg::NCH-1:0] = s_ff.chan_en;
      end else if (addr == tir_pkg::OFF_CHAN_FLAG) begin
        nxt_s.rdata[tir_pkg::NCH-1:0] = s_ff.chan_flag;
      end else if (addr == tir_pkg::OFF_ACC_CTL) begin
        nxt_s.rdata[tir_pkg::CTL_W-1:0] = s_ff.ctl;
      end else if (addr == tir_pkg::OFF_OVF_FLAG) begin
        nxt_s.rdata[tir_pkg::FLG_W-1:0] = s_ff.ovf_flag;
      end else if (addr == tir_pkg::OFF_ACC_CNT) begin
        nxt_s.rdata[tir_pkg::ACC_W-1:0] = s_ff.acc_cnt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= tir_pkg::ST_RESET;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rdata;
  assign req = s_ff.req;
  assign irq = s_ff.irq;

  property p_chan_level;
    @(posedge ref_clk) disable iff (rst)
      s_ff.req.chan == (s_ff.chan_flag & s_ff.chan_en);
  endproperty
  a_chan_level: assert property (p_chan_level) else $error("channel request mismatch");

  property p_chan_set;
    @(posedge ref_clk) disable iff (rst)
      clk_en && chan_event[0] && s_ff.chan_en[0] && !wr_stb |=> s_ff.req.chan[0];
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("channel event lost");

  property p_ai_req;
    @(posedge ref_clk) disable iff (rst)
      clk_en && ai_evt && s_ff.ctl[tir_pkg::CTL_AI_IE] && !wr_stb |=> req.acc_in && irq;
  endproperty
  a_ai_req: assert property (p_ai_req) else $error("input request missing");

  property p_gate_trail;
    @(posedge ref_clk) disable iff (rst)
      clk_en && s_ff.ctl[tir_pkg::CTL_ACC_EN] && s_ff.ctl[tir_pkg::CTL_GATED] &&
      trail_edge && !wr_stb |=> s_ff.ovf_flag[tir_pkg::FLG_AI];
  endproperty
  a_gate_trail: assert property (p_gate_trail) else $error("trailing edge missed");

  property p_ao_wrap;
    @(posedge ref_clk) disable iff (rst)
      clk_en && ao_evt && !wr_stb |=>
        s_ff.ovf_flag[tir_pkg::FLG_AO] && (s_ff.acc_cnt == tir_pkg::ACC_ZERO);
  endproperty
  a_ao_wrap: assert property (p_ao_wrap) else $error("overflow wrap wrong");

  property p_ao_req;
    @(posedge ref_clk) disable iff (rst)
      req.acc_ovf == (s_ff.ovf_flag[tir_pkg::FLG_AO] & s_ff.ctl[tir_pkg::CTL_AO_IE]);
  endproperty
  a_ao_req: assert property (p_ao_req) else $error("overflow request mismatch");

  property p_co_req;
    @(posedge ref_clk) disable iff (rst)
      clk_en && counter_overflow_evt && s_ff.ctl[tir_pkg::CTL_CO_IE] && !wr_stb
        |=> req.cnt_ovf [*2] or (req.cnt_ovf ##1 $past(wr_stb));
  endproperty
  a_co_req: assert property (p_co_req) else $error("counter request missing");

  property p_zero_ignored;
    @(posedge ref_clk) disable iff (rst)
      clk_en && wr_ovf_flag && !wdata[tir_pkg::FLG_AO] && s_ff.ovf_flag[tir_pkg::FLG_AO]
        |=> s_ff.ovf_flag[tir_pkg::FLG_AO];
  endproperty
  a_zero_ignored: assert property (p_zero_ignored) else $error("zero write cleared");

  property p_one_clears;
    @(posedge ref_clk) disable iff (rst)
      clk_en && wr_ovf_flag && wdata[tir_pkg::FLG_AI] && !ai_evt
        |=> !s_ff.ovf_flag[tir_pkg::FLG_AI];
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("one write kept flag");

  property p_irq_or;
    @(posedge ref_clk) disable iff (rst)
      irq == (|req);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");

  // Frozen cycles drop event pulses; sources must repeat them
  property p_freeze;
    @(posedge ref_clk) disable iff (rst)
      !clk_en |=> $stable(s_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_rd_once;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !rd_stb |=> rdata == tir_pkg::RD_ZERO;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data stood too long");

  property p_edge_flag;
    @(posedge ref_clk) disable iff (rst)
      clk_en && s_ff.ctl[tir_pkg::CTL_ACC_EN] && !s_ff.ctl[tir_pkg::CTL_GATED] &&
      sel_edge && !wr_stb |=> s_ff.ovf_flag[tir_pkg::FLG_AI];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("selected edge missed");

  property p_co_flag;
    @(posedge ref_clk) disable iff (rst)
      clk_en && counter_overflow_evt |=> s_ff.ovf_flag[tir_pkg::FLG_CO];
  endproperty
  a_co_flag: assert property (p_co_flag) else $error("counter overflow flag lost");

  property p_acc_idle;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !s_ff.ctl[tir_pkg::CTL_ACC_EN] && !wr_stb |=> $stable(s_ff.acc_cnt);
  endproperty
  a_acc_idle: assert property (p_acc_idle) else $error("idle accumulator moved");

  c_chan: cover property (@(posedge ref_clk) disable iff (rst) req.chan[3] ##1 !req.chan[3]);
  c_wrap: cover property (@(posedge ref_clk) disable iff (rst) clk_en && ao_evt);
  c_trail: cover property (@(posedge ref_clk) disable iff (rst)
    clk_en && s_ff.ctl[tir_pkg::CTL_GATED] && ai_evt);
  c_edge: cover property (@(posedge ref_clk) disable iff (rst)
    clk_en && !s_ff.ctl[tir_pkg::CTL_GATED] && ai_evt);
  c_cnt_ovf: cover property (@(posedge ref_clk) disable iff (rst) req.cnt_ovf && irq);
endmodule : tir_top
